// ---- core/cije_defs.vh ----
// Purpose: constants for the increment/jump/return execution slice
// Assumes: 8-bit cpu, 16-bit program counter
// Notes:   offsets are byte addresses on apb; flags sits at four times its index
`ifndef CIJE_DEFS_VH
`define CIJE_DEFS_VH
`define CIJE_OP_IDLE       8'h6F
`define CIJE_OP_INC_R      8'h20
`define CIJE_OP_INC_IR     8'h21
`define CIJE_OP_WORD_INCREMENT_OP_RR    8'hA0
`define CIJE_OP_WORD_INCREMENT_OP_IR    8'hA1
`define CIJE_OP_INTERRUPT_RETURN_OP       8'hBF
`define CIJE_OP_JP_IRR     8'h30
`define CIJE_LO_INC_WR     4'hE
`define CIJE_LO_JP_CC      4'hD
`define CIJE_LO_JR_CC      4'hB
`define CIJE_CYC_INC       4'h4
`define CIJE_CYC_WORD_INCREMENT_OP      4'h8
`define CIJE_CYC_IDLE      4'h4
`define CIJE_CYC_INTERRUPT_RETURN_OP_N    4'hA
`define CIJE_CYC_INTERRUPT_RETURN_OP_F    4'h6
`define CIJE_CYC_JP        4'h8
`define CIJE_CYC_JR        4'h6
`define CIJE_FLAG_C        7
`define CIJE_FLAG_Z        6
`define CIJE_FLAG_S        5
`define CIJE_FLAG_V        4
`define CIJE_FLAG_D        3
`define CIJE_FLAG_H        2
`define CIJE_FLAG_FIS      1
`define CIJE_IDX_FLAGS     8'hD5
`define CIJE_OFF_FLAGS     {`CIJE_IDX_FLAGS, 2'b00}
`define CIJE_OFF_CTRL      10'h000
`define CIJE_OFF_INSTR     10'h004
`define CIJE_OFF_OPER      10'h008
`define CIJE_OFF_PC        10'h00C
`define CIJE_OFF_IP        10'h010
`define CIJE_OFF_SP        10'h014
`define CIJE_OFF_STAT      10'h018
`define CIJE_OFF_RESULT    10'h01C
`define CIJE_OFF_SHADOW    10'h020
`endif

// ---- core/cije_cond.v ----
// Purpose: condition code evaluation against flags
// Assumes: flags laid out c,z,s,v in bits 7..4
// Notes:   fixed sixteen-entry decode
`timescale 1ns/100ps
`default_nettype none
`include "cije_defs.vh"
module cije_cond (
   input  wire [3:0] cc,
   input  wire [7:0] flags,
   output reg        cc_true
);
   reg c;
   reg z;
   reg s;
   reg v;
   always @* begin
      c = flags[`CIJE_FLAG_C];
      z = flags[`CIJE_FLAG_Z];
      s = flags[`CIJE_FLAG_S];
      v = flags[`CIJE_FLAG_V];
      case (cc)
         4'h0:    cc_true = 1'b0;
         4'h1:    cc_true = s ^ v;
         4'h2:    cc_true = z | (s ^ v);
         4'h3:    cc_true = c | z;
         4'h4:    cc_true = v;
         4'h5:    cc_true = s;
         4'h6:    cc_true = z;
         4'h7:    cc_true = c;
         4'h8:    cc_true = 1'b1;
         4'h9:    cc_true = ~(s ^ v);
         4'hA:    cc_true = ~(z | (s ^ v));
         4'hB:    cc_true = ~c & ~z;
         4'hC:    cc_true = ~v;
         4'hD:    cc_true = ~s;
         4'hE:    cc_true = ~z;
         4'hF:    cc_true = ~c;
         default: cc_true = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ---- core/cije_incr.v ----
// Purpose: byte or word increment with flag results
// Assumes: word is high byte first
// Notes:   carry, d, h untouched by caller
`timescale 1ns/100ps
`default_nettype none
module cije_incr (
   input  wire [15:0] opnd,
   input  wire        word,
   output reg  [15:0] result,
   output reg         z_out,
   output reg         s_out,
   output reg         v_out
);
   always @* begin
      if (word) begin
         result = opnd + 16'h0001;
         z_out  = (result == 16'h0000);
         s_out  = result[15];
         v_out  = (opnd == 16'h7FFF);
      end else begin
         result = {8'h00, opnd[7:0] + 8'h01};
         z_out  = (result[7:0] == 8'h00);
         s_out  = result[7];
         v_out  = (opnd[7:0] == 8'h7F);
      end
   end
endmodule
`default_nettype wire

// ---- core/cije_exec.v ----
// Purpose: executes idle, inc, word_increment_op, interrupt_return_op, jp and jr over apb-loaded state
// Assumes: software loads opcode, operand, pc, ip, sp then writes go
// Notes:   stack and register file lie outside; popped flags come via operand register, popped pc via upper half of go write
// Notes on behaviour
// - idle gates cpu clock, oscillator runs
// - idle ends on interrupt or reset
// - byte increment adds one, four cycles
// - increments set z s v only
// - word increment adds one, eight cycles
// - normal return pops flags, pc, enables
// - fast return chosen when fis set
// - fast return swaps pc/ip, clears fis
// - fast interrupt swaps pc and ip
// - conditional jump loads pc if true
// - opcode 30 loads pc from pair
// - decode three-byte and two-byte jumps
// - relative jump adds signed displacement
// - base is byte after jump
// - relative jump two bytes, six cycles
// - idle and jumps keep flags
`timescale 1ns/100ps
`default_nettype none
`include "cije_defs.vh"
module cije_exec (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [9:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        irq,
   output reg         cpu_clk_en_ff,
   output reg         int_enable_ff
);
   localparam S_IDLE = 3'b001;
   localparam S_RUN  = 3'b010;
   localparam S_HALT = 3'b100;

   reg [2:0]  state_ff;
   reg [7:0]  instr_ff;
   reg [15:0] oper_ff;
   reg [15:0] pc_ff;
   reg [15:0] ip_ff;
   reg [15:0] sp_ff;
   reg [7:0]  flags_ff;
   reg [7:0]  shadow_ff;
   reg [15:0] result_ff;
   reg [3:0]  cnt_ff;
   reg        done_ff;
   reg        bad_ff;
   reg [2:0]  nxt_state;
   reg [3:0]  nxt_cnt;

   // byte increment: working-register form or the two-byte forms
   function is_inc_op;
      input [7:0] op;
      begin
         is_inc_op = (op == `CIJE_OP_INC_R) || (op == `CIJE_OP_INC_IR) || (op[3:0] == `CIJE_LO_INC_WR);
      end
   endfunction

   // word increment on a pair or an indirect register
   function is_word_increment_op_op;
      input [7:0] op;
      begin
         is_word_increment_op_op = (op == `CIJE_OP_WORD_INCREMENT_OP_RR) || (op == `CIJE_OP_WORD_INCREMENT_OP_IR);
      end
   endfunction

   function is_jp_cc_op;
      input [7:0] op;
      begin
         is_jp_cc_op = (op[3:0] == `CIJE_LO_JP_CC);
      end
   endfunction

   function is_jr_op;
      input [7:0] op;
      begin
         is_jr_op = (op[3:0] == `CIJE_LO_JR_CC);
      end
   endfunction

   function [15:0] jr_target;
      input [15:0] pc;
      input [7:0]  disp;
      begin
         jr_target = pc + 16'h0002 + {{8{disp[7]}}, disp};
      end
   endfunction

   wire        wr = psel & penable & pwrite;
   wire        rd_sel = psel & ~penable & ~pwrite;
   wire        go = wr && (paddr == `CIJE_OFF_CTRL) && pwdata[0] && (state_ff == S_IDLE);
   wire        fint = wr && (paddr == `CIJE_OFF_CTRL) && pwdata[1];
   wire [3:0]  lo = instr_ff[3:0];
   wire        cc_true;
   wire [15:0] inc_res;
   wire        inc_z;
   wire        inc_s;
   wire        inc_v;
   wire        is_word = is_word_increment_op_op(instr_ff);

   cije_cond u_cond (
      .cc      (instr_ff[7:4]),
      .flags   (flags_ff),
      .cc_true (cc_true)
   );

   cije_incr u_incr (
      .opnd   (oper_ff),
      .word   (is_word),
      .result (inc_res),
      .z_out  (inc_z),
      .s_out  (inc_s),
      .v_out  (inc_v)
   );

   // cycle count per opcode; 0 marks unknown opcode
   function [3:0] cyc_of;
      input [7:0] op;
      input       fast_interrupt_status_bit;
      begin
         if (op == `CIJE_OP_IDLE)
            cyc_of = `CIJE_CYC_IDLE;
         else if (is_inc_op(op))
            cyc_of = `CIJE_CYC_INC;
         else if (is_word_increment_op_op(op))
            cyc_of = `CIJE_CYC_WORD_INCREMENT_OP;
         else if (op == `CIJE_OP_INTERRUPT_RETURN_OP)
            cyc_of = fast_interrupt_status_bit ? `CIJE_CYC_INTERRUPT_RETURN_OP_F : `CIJE_CYC_INTERRUPT_RETURN_OP_N;
         else if (op == `CIJE_OP_JP_IRR || is_jp_cc_op(op))
            cyc_of = `CIJE_CYC_JP;
         else if (is_jr_op(op))
            cyc_of = `CIJE_CYC_JR;
         else
            cyc_of = 4'h0;
      end
   endfunction

   always @* begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         S_IDLE: begin
            if (go && cyc_of(instr_ff, flags_ff[`CIJE_FLAG_FIS]) != 4'h0) begin
               nxt_state = S_RUN;
               nxt_cnt   = cyc_of(instr_ff, flags_ff[`CIJE_FLAG_FIS]) - 4'h1;
            end
         end
         S_RUN: begin
            if (cnt_ff == 4'h0)
               nxt_state = (instr_ff == `CIJE_OP_IDLE) ? S_HALT : S_IDLE;
            else
               nxt_cnt = cnt_ff - 4'h1;
         end
         S_HALT: begin
            if (irq)
               nxt_state = S_IDLE;
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff      <= S_IDLE;
         cnt_ff        <= 4'h0;
         instr_ff      <= 8'h00;
         oper_ff       <= 16'h0000;
         pc_ff         <= 16'h0000;
         ip_ff         <= 16'h0000;
         sp_ff         <= 16'h0000;
         flags_ff      <= 8'h00;
         shadow_ff     <= 8'h00;
         result_ff     <= 16'h0000;
         done_ff       <= 1'b0;
         bad_ff        <= 1'b0;
         cpu_clk_en_ff <= 1'b1;
         int_enable_ff <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         cnt_ff        <= nxt_cnt;
         cpu_clk_en_ff <= (nxt_state != S_HALT);
         if (go)
            done_ff <= 1'b0;
         if (go && cyc_of(instr_ff, flags_ff[`CIJE_FLAG_FIS]) == 4'h0)
            bad_ff <= 1'b1;
         if (wr && state_ff == S_IDLE) begin
            case (paddr)
               `CIJE_OFF_INSTR:  instr_ff  <= pwdata[7:0];
               `CIJE_OFF_OPER:   oper_ff   <= pwdata[15:0];
               `CIJE_OFF_PC:     pc_ff     <= pwdata[15:0];
               `CIJE_OFF_IP:     ip_ff     <= pwdata[15:0];
               `CIJE_OFF_SP:     sp_ff     <= pwdata[15:0];
               `CIJE_OFF_FLAGS:  flags_ff  <= pwdata[7:0];
               `CIJE_OFF_SHADOW: shadow_ff <= pwdata[7:0];
               `CIJE_OFF_STAT:   bad_ff    <= bad_ff & ~pwdata[1];
               default:          ;
            endcase
         end
         if (fint && state_ff == S_IDLE) begin
            pc_ff     <= ip_ff;
            ip_ff     <= pc_ff;
            shadow_ff <= flags_ff;
            flags_ff  <= flags_ff | 8'h02;
         end
         if (state_ff == S_RUN && cnt_ff == 4'h0) begin
            done_ff <= 1'b1;
            if (instr_ff == `CIJE_OP_INTERRUPT_RETURN_OP) begin
               if (flags_ff[`CIJE_FLAG_FIS]) begin
                  pc_ff    <= ip_ff;
                  ip_ff    <= pc_ff;
                  flags_ff <= shadow_ff & 8'hFD;
               end else begin
                  flags_ff <= oper_ff[7:0];
                  pc_ff    <= result_ff;
                  sp_ff    <= sp_ff + 16'h0003;
               end
               int_enable_ff <= 1'b1;
            end else if (is_inc_op(instr_ff) || is_word) begin
               result_ff                <= inc_res;
               flags_ff[`CIJE_FLAG_Z]   <= inc_z;
               flags_ff[`CIJE_FLAG_S]   <= inc_s;
               flags_ff[`CIJE_FLAG_V]   <= inc_v;
               pc_ff                    <= pc_ff + ((lo == `CIJE_LO_INC_WR) ? 16'h0001 : 16'h0002);
            end else if (instr_ff == `CIJE_OP_JP_IRR) begin
               pc_ff <= oper_ff;
            end else if (is_jp_cc_op(instr_ff)) begin
               pc_ff <= cc_true ? oper_ff : pc_ff + 16'h0003;
            end else if (is_jr_op(instr_ff)) begin
               pc_ff <= cc_true ? jr_target(pc_ff, oper_ff[7:0]) : pc_ff + 16'h0002;
            end else begin
               pc_ff <= pc_ff + 16'h0001;
            end
         end
         // popped return address rides in the upper half of the go write
         if (go && instr_ff == `CIJE_OP_INTERRUPT_RETURN_OP)
            result_ff <= pwdata[31:16];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (rd_sel) begin
            case (paddr)
               `CIJE_OFF_CTRL:   prdata <= 32'h00000000;
               `CIJE_OFF_INSTR:  prdata <= {24'h000000, instr_ff};
               `CIJE_OFF_OPER:   prdata <= {16'h0000, oper_ff};
               `CIJE_OFF_PC:     prdata <= {16'h0000, pc_ff};
               `CIJE_OFF_IP:     prdata <= {16'h0000, ip_ff};
               `CIJE_OFF_SP:     prdata <= {16'h0000, sp_ff};
               `CIJE_OFF_FLAGS:  prdata <= {24'h000000, flags_ff};
               `CIJE_OFF_SHADOW: prdata <= {24'h000000, shadow_ff};
               `CIJE_OFF_RESULT: prdata <= {16'h0000, result_ff};
               `CIJE_OFF_STAT:   prdata <= {26'h0000000, int_enable_ff, ~cpu_clk_en_ff, bad_ff, done_ff,
                                            state_ff == S_RUN, state_ff == S_HALT};
               default: begin
                  prdata  <= 32'h00000000;
               end
            endcase
         end
         if (psel & ~penable) begin
            case (paddr)
               `CIJE_OFF_CTRL, `CIJE_OFF_INSTR, `CIJE_OFF_OPER, `CIJE_OFF_PC, `CIJE_OFF_IP,
               `CIJE_OFF_SP, `CIJE_OFF_FLAGS, `CIJE_OFF_SHADOW, `CIJE_OFF_RESULT, `CIJE_OFF_STAT:
                  pslverr <= 1'b0;
               default:
                  pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/cije_exec_asserts.sv ----
// Purpose: bus and halt checks on cije_exec
// Assumes: one clock domain
// Notes:   bound to every cije_exec
`timescale 1ns/100ps
`default_nettype none
module cije_exec_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [9:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic        cpu_clk_en_ff,
   input wire logic        int_enable_ff
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_woken;
      ##[1:3] cpu_clk_en_ff;
   endsequence
   property p_rdy; s_setup |=> pready; endproperty
   property p_rdy_only; !(psel && !penable) |=> !pready; endproperty
   property p_rdy_one; pready |=> !pready; endproperty
   property p_err_rdy; pslverr |-> pready; endproperty
   property p_unmap; s_setup ##0 (paddr == 10'h024 && !pwrite) |=> pslverr && prdata == 32'h0; endproperty
   property p_map; s_setup ##0 (paddr == 10'h018) |=> !pslverr; endproperty
   property p_halt_hold; !cpu_clk_en_ff && !irq |=> !cpu_clk_en_ff; endproperty
   property p_wake; !cpu_clk_en_ff && irq |-> s_woken; endproperty
   property p_rst; $rose(presetn) |-> cpu_clk_en_ff && !int_enable_ff; endproperty
   a_rdy: assert property (p_rdy) else $error("pready late");
   a_rdy_only: assert property (p_rdy_only) else $error("stray pready");
   a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
   a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   a_map: assert property (p_map) else $error("mapped error");
   a_halt_hold: assert property (p_halt_hold) else $error("halt left");
   a_wake: assert property (p_wake) else $error("no wake");
   a_rst: assert property (p_rst) else $error("bad reset state");
endmodule
bind cije_exec cije_exec_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq(irq), .cpu_clk_en_ff(cpu_clk_en_ff), .int_enable_ff(int_enable_ff));
`default_nettype wire

// ---- tb/cije_irq_src.sv ----
// Purpose: interrupt source beside the cpu
// Assumes: request held until served
// Notes:   raises irq some cycles after req
`timescale 1ns/100ps
`default_nettype none
module cije_irq_src #(parameter int DLY = 3) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic req,
   output var  logic irq_ff
);
   logic [3:0] cnt_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 4'h0;
         irq_ff <= 1'b0;
      end else begin
         cnt_ff <= req ? cnt_ff + ((cnt_ff < DLY) ? 4'h1 : 4'h0) : 4'h0;
         irq_ff <= req && cnt_ff == DLY;
      end
   end
endmodule
`default_nettype wire

// ---- tb/cije_exec_tb.sv ----
// Purpose: self-checking bench for the execution slice
// Assumes: flags byte sits in bits 7:0 of its word
// Notes:   wake comes from cije_irq_src
`timescale 1ns/100ps
`default_nettype none
`include "cije_defs.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module cpu_incr_jump_return_exec_tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic        wake_req;
   logic [9:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] rd;
   logic        er;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         irq;
   wire         clk_en;
   wire         int_en;
   int          mismatches;
   int          comparisons;
   cije_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .cpu_clk_en_ff(clk_en), .int_enable_ff(int_en));
   cije_irq_src i_irq (.pclk(pclk), .presetn(presetn), .req(wake_req), .irq_ff(irq));
   task automatic stop_test(input bit hang);
      if (hang)
         mismatches++;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (n == 16)
         stop_test(1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdr(input logic [9:0] a);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic run(input logic [7:0] op, input logic [15:0] o, input logic [15:0] pop);
      int n;
      wr(`CIJE_OFF_INSTR, {24'h0, op});
      wr(`CIJE_OFF_OPER, {16'h0, o});
      wr(`CIJE_OFF_CTRL, {pop, 16'h0001});
      for (n = 0; n < 20; n++) begin
         rdr(`CIJE_OFF_STAT);
         if (rd[2:1] === 2'b10)
            break;
      end
      if (n == 20)
         stop_test(1'b1);
   endtask
   task automatic t_reset;
      `CHK("clk_en", 1'b1, clk_en)
      rdr(10'h024);
      `CHK("err", 1'b1, er)
      `CHK("unmap", 32'h0, rd)
      $display("test reset done");
   endtask
   task automatic t_inc;
      int i;
      wr(`CIJE_OFF_FLAGS, 32'h8C);
      wr(`CIJE_OFF_PC, 32'h100);
      run(8'h7E, 16'h7F, 16'h0);
      rdr(`CIJE_OFF_RESULT);
      `CHK("inc", 8'h80, rd[7:0])
      rdr(`CIJE_OFF_FLAGS);
      `CHK("incf", 8'hBC, rd[7:0])
      rdr(`CIJE_OFF_PC);
      `CHK("incpc", 16'h101, rd[15:0])
      for (i = 0; i < 2; i++) begin
         run(8'h20 + i[7:0], 16'hFF, 16'h0);
         rdr(`CIJE_OFF_RESULT);
         `CHK("inc2", 8'h00, rd[7:0])
         rdr(`CIJE_OFF_FLAGS);
         `CHK("inc2f", 8'hCC, rd[7:0])
         run(8'hA0 + i[7:0], 16'h7FFF, 16'h0);
         rdr(`CIJE_OFF_RESULT);
         `CHK("word_increment_op", 16'h8000, rd[15:0])
         rdr(`CIJE_OFF_FLAGS);
         `CHK("incwf", 8'hBC, rd[7:0])
      end
      $display("test inc done");
   endtask
   task automatic t_jump;
      logic [7:0] op[8] = '{8'h8D, 8'h0D, 8'h8B, 8'h0B, 8'h8B, 8'h30, 8'h7D, 8'hFB};
      logic [15:0] od[8] = '{16'h1234, 16'h0, 16'h80, 16'h80, 16'h7F, 16'h120, 16'h2222, 16'h10};
      logic [15:0] ex[8] = '{16'h1234, 16'h1003, 16'hF82, 16'h1002, 16'h1081, 16'h120, 16'h2222, 16'h1002};
      int i;
      wr(`CIJE_OFF_FLAGS, 32'h8C);
      for (i = 0; i < 8; i++) begin
         wr(`CIJE_OFF_PC, 32'h1000);
         run(op[i], od[i], 16'h0);
         rdr(`CIJE_OFF_PC);
         `CHK("jpc", ex[i], rd[15:0])
      end
      rdr(`CIJE_OFF_FLAGS);
      `CHK("jf", 8'h8C, rd[7:0])
      $display("test jump done");
   endtask
   task automatic t_idle;
      int n;
      wr(`CIJE_OFF_INSTR, 32'h6F);
      wr(`CIJE_OFF_CTRL, 32'h1);
      for (n = 0; n < 20 && clk_en !== 1'b0; n++) @(posedge pclk);
      `CHK("halt", 1'b0, clk_en)
      wake_req <= 1'b1;
      for (n = 0; n < 20 && clk_en !== 1'b1; n++) @(posedge pclk);
      `CHK("wake", 1'b1, clk_en)
      wake_req <= 1'b0;
      rdr(`CIJE_OFF_FLAGS);
      `CHK("idlef", 8'h8C, rd[7:0])
      wr(`CIJE_OFF_INSTR, 32'h6F);
      wr(`CIJE_OFF_CTRL, 32'h1);
      repeat (8) @(posedge pclk);
      `CHK("halt2", 1'b0, clk_en)
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      `CHK("rstwake", 1'b1, clk_en)
      $display("test idle done");
   endtask
   task automatic t_interrupt_return_op;
      wr(`CIJE_OFF_FLAGS, 32'h0);
      wr(`CIJE_OFF_SP, 32'h40);
      run(8'hBF, 16'h55, 16'h0ABC);
      rdr(`CIJE_OFF_FLAGS);
      `CHK("nf", 8'h55, rd[7:0])
      rdr(`CIJE_OFF_PC);
      `CHK("npc", 16'h0ABC, rd[15:0])
      rdr(`CIJE_OFF_SP);
      `CHK("sp", 16'h43, rd[15:0])
      `CHK("ie", 1'b1, int_en)
      wr(`CIJE_OFF_FLAGS, 32'h44);
      wr(`CIJE_OFF_PC, 32'h200);
      wr(`CIJE_OFF_IP, 32'h100);
      wr(`CIJE_OFF_CTRL, 32'h2);
      rdr(`CIJE_OFF_PC);
      `CHK("fpc", 16'h100, rd[15:0])
      rdr(`CIJE_OFF_FLAGS);
      `CHK("fis", 1'b1, rd[1])
      run(8'hBF, 16'h0, 16'h0);
      rdr(`CIJE_OFF_PC);
      `CHK("rpc", 16'h200, rd[15:0])
      rdr(`CIJE_OFF_IP);
      `CHK("rip", 16'h100, rd[15:0])
      rdr(`CIJE_OFF_FLAGS);
      `CHK("rf", 8'h44, rd[7:0])
      $display("test interrupt_return_op done");
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      wake_req = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0;
      mismatches = 0;
      comparisons = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_inc();
      t_jump();
      t_idle();
      t_interrupt_return_op();
      stop_test(1'b0);
   end
endmodule
`default_nettype wire
